// ### shared/pabo_defines.svh
// Constants for the port A/B alternate function override block.
`ifndef PABO_DEFINES_SVH
`define PABO_DEFINES_SVH
`define PABO_PORT_W       8
`define PABO_RST_BYTE     8'h00
`define PABO_RST_BIT      1'b0
`define PABO_ON           1'b1
`define PABO_B_SCK        7
`define PABO_B_MISO       6
`define PABO_B_MOSI       5
`define PABO_B_SEL        4
`define PABO_B_CMP_NEG    3
`define PABO_B_CMP_POS    2
`define PABO_B_TMR_B      1
`define PABO_B_TMR_A      0
`endif

// ### shared/pabo_pkg.sv
// Types shared by the port A/B alternate function override block.
package pabo_pkg;
	typedef logic [7:0] pabo_byte_t;
	typedef enum logic [1:0] {
		PABO_SPI_OFF,
		PABO_SPI_MASTER,
		PABO_SPI_SLAVE
	} pabo_spi_role_t;
endpackage

// ### verilog/pabo_pin_ctl.sv
// One pin's generic override resolution: pull-up, drive enable and output value.
`timescale 1ns/100ps
`default_nettype none
module pabo_pin_ctl (
	input  wire logic pu_oe,
	input  wire logic pu_ov,
	input  wire logic dir_oe,
	input  wire logic dir_ov,
	input  wire logic val_oe,
	input  wire logic val_ov,
	input  wire logic dir_bit,
	input  wire logic latch_bit,
	input  wire logic pu_off,
	output logic      drive_en,
	output logic      drive_val,
	output logic      pu_on
);
	always_comb begin
		drive_en = dir_oe ? dir_ov : dir_bit;
		drive_val = val_oe ? val_ov : latch_bit;
		// Without a pull-up override, only the exact pattern dir=0, latch=1, global off=0 enables the pull-up.
		pu_on = pu_oe ? pu_ov : (!dir_bit && latch_bit && !pu_off);
	end
endmodule // pabo_pin_ctl
`default_nettype wire

// ### verilog/pabo_top.sv
// Port A and port B alternate function override logic with registered pad controls.
`timescale 1ns/100ps
`default_nettype none
`include "pabo_defines.svh"
// Summary of operation
// - Port A pins carry multiplexed address/data byte
// - External memory overrides pull-up, direction, value
// - Port A drives during address or write
// - Drive address bit, write data bit, or both ORed
// - Pull-up only idle and latch bit one
// - Raw port A input feeds incoming data
// - Serial clock input as slave, dir bit master
// - Master-in pin input as master, dir slave
// - Master-out pin input as slave, dir master
// - Select pin input as slave, dir master
// - Slave active only while select low
// - Forced-input SPI pins keep latch pull-up
// - Bits 1, 0 feed timer count inputs
// - Bit 0 may carry timer A compare
// - Bits 2, 3 feed comparator inputs
// - Default pull-up needs dir 0, latch 1
// - Global pull-up off disables every pull-up except port A under external memory
module pabo_top (
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire logic                ext_mem_enable,
	input  wire logic                addr_phase_active,
	input  wire logic                write_strobe,
	input  wire pabo_pkg::pabo_byte_t mem_addr_low,
	input  wire pabo_pkg::pabo_byte_t mem_data_out,
	input  wire pabo_pkg::pabo_byte_t porta_latch_bit,
	input  wire pabo_pkg::pabo_byte_t porta_dir_bit,
	input  wire pabo_pkg::pabo_byte_t porta_pin_raw_input,
	input  wire logic                global_pullup_off,
	input  wire logic                spi_enable,
	input  wire logic                spi_master,
	input  wire logic                spi_sck_out,
	input  wire logic                spi_slave_data_out,
	input  wire logic                spi_master_data_out,
	input  wire logic                timer_a_compare_en,
	input  wire logic                timer_a_compare_out,
	input  wire pabo_pkg::pabo_byte_t portb_latch_bit,
	input  wire pabo_pkg::pabo_byte_t portb_dir_bit,
	input  wire pabo_pkg::pabo_byte_t portb_pin_raw_input,
	output pabo_pkg::pabo_byte_t     porta_oe,
	output pabo_pkg::pabo_byte_t     porta_out,
	output pabo_pkg::pabo_byte_t     porta_pullup,
	output pabo_pkg::pabo_byte_t     mem_data_in,
	output pabo_pkg::pabo_byte_t     portb_oe,
	output pabo_pkg::pabo_byte_t     portb_out,
	output pabo_pkg::pabo_byte_t     portb_pullup,
	output logic                     input_en_override_en,
	output logic                     input_en_override_val,
	output logic                     spi_sck_in,
	output logic                     spi_master_data_in,
	output logic                     spi_slave_data_in,
	output logic                     spi_slave_select,
	output logic                     spi_slave_active,
	output logic                     timer_a_count_in,
	output logic                     timer_b_count_in,
	output logic                     comparator_pos_in,
	output logic                     comparator_neg_in
);
	import pabo_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Override values for port A.

	// Override requests for port A, one bit per pin.
	pabo_byte_t     a_pu_oe;
	pabo_byte_t     a_pu_ov;
	pabo_byte_t     a_dir_oe;
	pabo_byte_t     a_dir_ov;
	pabo_byte_t     a_val_oe;
	pabo_byte_t     a_val_ov;
	pabo_byte_t     a_drive_en;
	pabo_byte_t     a_drive_val;
	pabo_byte_t     a_pullup;
	// Override requests for port B, one bit per pin.
	pabo_byte_t     b_pu_oe;
	pabo_byte_t     b_pu_ov;
	pabo_byte_t     b_dir_oe;
	pabo_byte_t     b_dir_ov;
	pabo_byte_t     b_val_oe;
	pabo_byte_t     b_val_ov;
	pabo_byte_t     b_drive_en;
	pabo_byte_t     b_drive_val;
	pabo_byte_t     b_pullup;
	pabo_spi_role_t spi_role;
	logic           bus_busy;

	always_comb begin
		bus_busy = write_strobe || addr_phase_active;
		// Each pin n carries address/data bit n, so whole-byte operations suffice.
		a_pu_oe = {`PABO_PORT_W{ext_mem_enable}};
		a_dir_oe = {`PABO_PORT_W{ext_mem_enable}};
		a_val_oe = {`PABO_PORT_W{ext_mem_enable}};
		a_dir_ov = {`PABO_PORT_W{bus_busy}};
		a_val_ov = (mem_addr_low & {`PABO_PORT_W{addr_phase_active}})
			| (mem_data_out & {`PABO_PORT_W{write_strobe}});
		a_pu_ov = porta_latch_bit & {`PABO_PORT_W{!bus_busy}};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Override values for port B.

	always_comb begin
		if (!spi_enable) begin
			spi_role = PABO_SPI_OFF;
		end else if (spi_master) begin
			spi_role = PABO_SPI_MASTER;
		end else begin
			spi_role = PABO_SPI_SLAVE;
		end
		b_pu_oe = `PABO_RST_BYTE;
		b_pu_ov = `PABO_RST_BYTE;
		b_dir_oe = `PABO_RST_BYTE;
		b_dir_ov = `PABO_RST_BYTE;
		b_val_oe = `PABO_RST_BYTE;
		b_val_ov = `PABO_RST_BYTE;
		case (spi_role)
			PABO_SPI_SLAVE: begin
				// As slave, clock, data-in and select are forced to input.
				b_dir_oe[`PABO_B_SCK] = `PABO_ON;
				b_dir_oe[`PABO_B_MOSI] = `PABO_ON;
				b_dir_oe[`PABO_B_SEL] = `PABO_ON;
				b_val_oe[`PABO_B_MISO] = `PABO_ON;
				b_val_ov[`PABO_B_MISO] = spi_slave_data_out;
			end
			PABO_SPI_MASTER: begin
				b_dir_oe[`PABO_B_MISO] = `PABO_ON;
				b_val_oe[`PABO_B_SCK] = `PABO_ON;
				b_val_ov[`PABO_B_SCK] = spi_sck_out;
				b_val_oe[`PABO_B_MOSI] = `PABO_ON;
				b_val_ov[`PABO_B_MOSI] = spi_master_data_out;
			end
			default: begin
			end
		endcase
		b_val_oe[`PABO_B_TMR_A] = timer_a_compare_en;
		b_val_ov[`PABO_B_TMR_A] = timer_a_compare_out;
		// Every direction override on port B forces an input, so the same mask hands the
		// pull-up to the latch bit whatever the direction bit says, still under the global disable.
		b_pu_oe = b_dir_oe;
		b_pu_ov = portb_latch_bit & b_dir_oe & {`PABO_PORT_W{!global_pullup_off}};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-pin resolution.

	genvar gi;
	generate
		for (gi = 0; gi < `PABO_PORT_W; gi++) begin : g_pin
			pabo_pin_ctl u_a (
				.pu_oe     (a_pu_oe[gi]),
				.pu_ov     (a_pu_ov[gi]),
				.dir_oe    (a_dir_oe[gi]),
				.dir_ov    (a_dir_ov[gi]),
				.val_oe    (a_val_oe[gi]),
				.val_ov    (a_val_ov[gi]),
				.dir_bit   (porta_dir_bit[gi]),
				.latch_bit (porta_latch_bit[gi]),
				.pu_off    (global_pullup_off),
				.drive_en  (a_drive_en[gi]),
				.drive_val (a_drive_val[gi]),
				.pu_on     (a_pullup[gi])
			);
			pabo_pin_ctl u_b (
				.pu_oe     (b_pu_oe[gi]),
				.pu_ov     (b_pu_ov[gi]),
				.dir_oe    (b_dir_oe[gi]),
				.dir_ov    (b_dir_ov[gi]),
				.val_oe    (b_val_oe[gi]),
				.val_ov    (b_val_ov[gi]),
				.dir_bit   (portb_dir_bit[gi]),
				.latch_bit (portb_latch_bit[gi]),
				.pu_off    (global_pullup_off),
				.drive_en  (b_drive_en[gi]),
				.drive_val (b_drive_val[gi]),
				.pu_on     (b_pullup[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Registered pad controls for port A and the incoming data byte.

	pabo_byte_t next_porta_oe;
	pabo_byte_t next_porta_out;
	pabo_byte_t next_porta_pullup;
	pabo_byte_t next_mem_data_in;

	always_comb begin
		next_porta_oe = a_drive_en;
		next_porta_out = a_drive_val;
		next_porta_pullup = a_pullup;
		// One register stage only; it is not a synchroniser, so the memory side must not
		// treat this byte as safe against metastability.
		next_mem_data_in = porta_pin_raw_input;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			porta_oe <= `PABO_RST_BYTE;
			porta_out <= `PABO_RST_BYTE;
			porta_pullup <= `PABO_RST_BYTE;
			mem_data_in <= `PABO_RST_BYTE;
		end else begin
			porta_oe <= next_porta_oe;
			porta_out <= next_porta_out;
			porta_pullup <= next_porta_pullup;
			mem_data_in <= next_mem_data_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered pad controls for port B.

	pabo_byte_t next_portb_oe;
	pabo_byte_t next_portb_out;
	pabo_byte_t next_portb_pullup;

	always_comb begin
		next_portb_oe = b_drive_en;
		next_portb_out = b_drive_val;
		next_portb_pullup = b_pullup;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portb_oe <= `PABO_RST_BYTE;
			portb_out <= `PABO_RST_BYTE;
			portb_pullup <= `PABO_RST_BYTE;
		end else begin
			portb_oe <= next_portb_oe;
			portb_out <= next_portb_out;
			portb_pullup <= next_portb_pullup;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered inputs handed to the SPI, the timers and the comparator.

	logic next_in_ov_en;
	logic next_in_ov_val;
	logic next_sck_in;
	logic next_miso_in;
	logic next_mosi_in;
	logic next_sel;
	logic next_slave_active;
	logic next_tmr_a;
	logic next_tmr_b;
	logic next_cmp_pos;
	logic next_cmp_neg;

	always_comb begin
		// No alternate function on these ports ever overrides the digital input enable.
		next_in_ov_en = `PABO_RST_BIT;
		next_in_ov_val = `PABO_RST_BIT;
		next_sck_in = portb_pin_raw_input[`PABO_B_SCK];
		next_miso_in = portb_pin_raw_input[`PABO_B_MISO];
		next_mosi_in = portb_pin_raw_input[`PABO_B_MOSI];
		next_sel = portb_pin_raw_input[`PABO_B_SEL];
		// A slave is selected only while its select pin reads low.
		next_slave_active = (spi_role == PABO_SPI_SLAVE) && !portb_pin_raw_input[`PABO_B_SEL];
		next_tmr_b = portb_pin_raw_input[`PABO_B_TMR_B];
		next_tmr_a = portb_pin_raw_input[`PABO_B_TMR_A];
		// The comparator sees the pad level; digital buffering here is a sampled copy only.
		next_cmp_pos = portb_pin_raw_input[`PABO_B_CMP_POS];
		next_cmp_neg = portb_pin_raw_input[`PABO_B_CMP_NEG];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			input_en_override_en <= `PABO_RST_BIT;
			input_en_override_val <= `PABO_RST_BIT;
			spi_sck_in <= `PABO_RST_BIT;
			spi_master_data_in <= `PABO_RST_BIT;
			spi_slave_data_in <= `PABO_RST_BIT;
			spi_slave_select <= `PABO_RST_BIT;
			spi_slave_active <= `PABO_RST_BIT;
			timer_a_count_in <= `PABO_RST_BIT;
			timer_b_count_in <= `PABO_RST_BIT;
			comparator_pos_in <= `PABO_RST_BIT;
			comparator_neg_in <= `PABO_RST_BIT;
		end else begin
			input_en_override_en <= next_in_ov_en;
			input_en_override_val <= next_in_ov_val;
			spi_sck_in <= next_sck_in;
			spi_master_data_in <= next_miso_in;
			spi_slave_data_in <= next_mosi_in;
			spi_slave_select <= next_sel;
			spi_slave_active <= next_slave_active;
			timer_a_count_in <= next_tmr_a;
			timer_b_count_in <= next_tmr_b;
			comparator_pos_in <= next_cmp_pos;
			comparator_neg_in <= next_cmp_neg;
		end
	end
endmodule // pabo_top
`default_nettype wire

// ### bench/pabo_top_props.sv
// Port-level assertions for the port A/B override block.
`timescale 1ns/100ps
`default_nettype none
module pabo_top_props (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       ext_mem_enable,
	input wire logic       addr_phase_active,
	input wire logic       write_strobe,
	input wire logic [7:0] mem_addr_low,
	input wire logic [7:0] mem_data_out,
	input wire logic       global_pullup_off,
	input wire logic       spi_enable,
	input wire logic       spi_master,
	input wire logic [7:0] porta_oe,
	input wire logic [7:0] porta_out,
	input wire logic [7:0] porta_pullup,
	input wire logic [7:0] portb_oe,
	input wire logic [7:0] portb_latch_bit,
	input wire logic [7:0] portb_pullup
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_bus; ext_mem_enable && (addr_phase_active || write_strobe); endsequence
	sequence s_slave; spi_enable && !spi_master; endsequence
	bus_drive_a: assert property (s_bus |=> porta_oe == 8'hFF) else $error("bus not driven");
	bus_pullup_a: assert property (s_bus |=> porta_pullup == 8'h00) else $error("bus pull-up");
	addr_out_a: assert property (s_bus ##0 !write_strobe |=> porta_out == $past(mem_addr_low)) else $error("addr");
	data_out_a: assert property (s_bus ##0 !addr_phase_active |=> porta_out == $past(mem_data_out)) else $error("data");
	idle_float_a: assert property (ext_mem_enable && !(addr_phase_active || write_strobe) |=> porta_oe == 8'h00)
		else $error("idle drive");
	slave_dir_a: assert property (s_slave |=> (portb_oe & 8'hB0) == 8'h00) else $error("slave dir");
	master_dir_a: assert property (spi_enable && spi_master |=> !portb_oe[6]) else $error("master dir");
	pullup_off_a: assert property (global_pullup_off && !ext_mem_enable |=> porta_pullup == 8'h00)
		else $error("pull-up on");
	slave_pullup_a: assert property (s_slave ##0 !global_pullup_off |=>
		(portb_pullup & 8'hB0) == ($past(portb_latch_bit) & 8'hB0)) else $error("slave pull-up");
endmodule // pabo_top_props
bind pabo_top pabo_top_props u_pabo_top_props (.*);
`default_nettype wire

// ### bench/pabo_pad_model.sv
// Pad and far-side peer model resolving each pin level.
`timescale 1ns/100ps
`default_nettype none
module pabo_pad_model (
	input wire logic       clk,
	input wire logic [7:0] oe,
	input wire logic [7:0] out,
	input wire logic [7:0] pu,
	input wire logic [7:0] pen,
	input wire logic [7:0] pval,
	output logic     [7:0] pin
);
	logic [7:0] last = 8'h00;
	// A floating pin shows its inverted last level, so a stale value cannot pass for a driven one.
	assign pin = (oe & out) | (~oe & pen & pval) | (~oe & ~pen & (pu | ~last));
	always @(posedge clk) last <= pin;
endmodule // pabo_pad_model
`default_nettype wire

// ### bench/test_pabo_top.sv
// Random self-checking bench for the port A/B override block.
`timescale 1ns/100ps
`default_nettype none
module test_pabo_top;
	import pabo_pkg::*;
	logic clk = 1'b0, arst_n = 1'b0, ext_mem_enable, addr_phase_active, write_strobe, global_pullup_off, spi_enable;
	logic spi_master, spi_sck_out, spi_slave_data_out, spi_master_data_out, timer_a_compare_en, timer_a_compare_out;
	logic input_en_override_en, input_en_override_val, spi_sck_in, spi_master_data_in, spi_slave_data_in;
	logic spi_slave_select, spi_slave_active, timer_a_count_in, timer_b_count_in, comparator_pos_in, comparator_neg_in;
	pabo_byte_t mem_addr_low, mem_data_out, porta_latch_bit, porta_dir_bit, porta_pin_raw_input, portb_latch_bit;
	pabo_byte_t portb_dir_bit, portb_pin_raw_input, mem_data_in, porta_oe, porta_out, porta_pullup, portb_oe;
	pabo_byte_t portb_out, portb_pullup;
	logic [31:0] peer;
	logic [66:0] act, exp_q;
	integer seed = 32'h12fe, error_cnt = 0, checks_done = 0;
	pabo_top u_pabo_top (.*);
	pabo_pad_model u_pad_a (.clk, .oe(porta_oe), .out(porta_out), .pu(porta_pullup), .pen(peer[7:0]),
		.pval(peer[15:8]), .pin(porta_pin_raw_input));
	pabo_pad_model u_pad_b (.clk, .oe(portb_oe), .out(portb_out), .pu(portb_pullup), .pen(peer[23:16]),
		.pval(peer[31:24]), .pin(portb_pin_raw_input));
	assign act = {porta_oe, porta_out & porta_oe, porta_pullup, mem_data_in, portb_oe, portb_out & portb_oe, portb_pullup,
		input_en_override_en, input_en_override_val, spi_sck_in, spi_master_data_in, spi_slave_data_in, spi_slave_select,
		spi_slave_active, timer_a_count_in, timer_b_count_in, comparator_pos_in, comparator_neg_in};
	always #50 clk = ~clk;
	function automatic logic [66:0] f_exp();
		pabo_byte_t ao, av, bo, bv, rb, fm;
		logic ad, sl;
		ad = addr_phase_active | write_strobe;
		sl = spi_enable & ~spi_master;
		rb = portb_pin_raw_input;
		ao = ext_mem_enable ? {8{ad}} : porta_dir_bit;
		av = (mem_addr_low & {8{addr_phase_active}}) | (mem_data_out & {8{write_strobe}});
		av = ext_mem_enable ? av : porta_latch_bit;
		fm = sl ? 8'hB0 : spi_enable ? 8'h40 : 8'h00;
		bo = portb_dir_bit & ~fm;
		bv = portb_latch_bit;
		if (sl)
			bv[6] = spi_slave_data_out;
		if (spi_enable & spi_master)
			{bv[7], bv[5]} = {spi_sck_out, spi_master_data_out};
		if (timer_a_compare_en)
			bv[0] = timer_a_compare_out;
		return {ao, av & ao, ext_mem_enable ? porta_latch_bit & {8{~ad}} : ~porta_dir_bit & porta_latch_bit &
			{8{~global_pullup_off}}, porta_pin_raw_input, bo, bv & bo, (~portb_dir_bit | fm) & portb_latch_bit &
			{8{~global_pullup_off}}, 2'b00, rb[7:4], sl & ~rb[4], rb[0], rb[1], rb[2], rb[3]};
	endfunction
	task automatic check(input logic [66:0] got, input logic [66:0] want);
		checks_done = checks_done + 1;
		if (got !== want) begin
			error_cnt = error_cnt + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic close_out();
		if (error_cnt == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic drive(input int i);
		{mem_addr_low, mem_data_out, porta_latch_bit, porta_dir_bit} = $random(seed);
		{portb_latch_bit, portb_dir_bit, peer[15:0]} = $random(seed);
		{peer[31:16], ext_mem_enable, addr_phase_active, write_strobe, global_pullup_off, spi_enable, spi_master,
			spi_sck_out, spi_slave_data_out, spi_master_data_out, timer_a_compare_en, timer_a_compare_out} = 27'($random(seed));
		case (i)
			0: {ext_mem_enable, addr_phase_active, write_strobe, mem_addr_low} = {3'b110, 8'hA5};
			1: {ext_mem_enable, addr_phase_active, write_strobe, mem_data_out} = {3'b101, 8'h3C};
			2: {ext_mem_enable, addr_phase_active, write_strobe} = 3'b100;
			3: {spi_enable, portb_dir_bit[3:2], portb_latch_bit[3:2]} = 5'h00;
			4, 5: {spi_enable, spi_master, peer[20], peer[28]} = {3'b101, i[0]};
		endcase
	endtask
	initial begin
		drive(-1);
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		for (int i = 0; i < 400; i++) begin
			drive(i);
			#1 exp_q = f_exp();
			@(negedge clk);
			check(act, exp_q);
			if (i == 200) begin
				arst_n = 1'b0;
				#1 check(act, 67'h0);
				@(negedge clk);
				arst_n = 1'b1;
			end
		end
		close_out();
	end
endmodule // test_pabo_top
`default_nettype wire
